// ---- core/ifec_pkg.sv ----
// Constants, register map and types for the interrupt flag and edge control block
package ifec_pkg;

  // Register byte offsets
  localparam logic [31:0] IFEC_CTRL_OFS     = 32'h0000_0000;
  localparam logic [31:0] IFEC_FLAG0_OFS    = 32'h0000_0004;
  localparam logic [31:0] IFEC_FLAG1_OFS    = 32'h0000_0008;
  localparam logic [31:0] IFEC_FLAG2_OFS    = 32'h0000_000c;
  localparam logic [31:0] IFEC_EVT_STAT_OFS = 32'h0000_0010;
  localparam logic [31:0] IFEC_EVT_MASK_OFS = 32'h0000_0014;

  // Widths
  localparam int IFEC_REG_W  = 16;
  localparam int IFEC_NUM_EXT = 5;
  localparam int IFEC_NUM_FLAG_REGS = 3;

  // Control register fields
  localparam int IFEC_ALT_BIT  = 15;
  localparam int IFEC_TDIS_BIT = 14;
  localparam int IFEC_POL_LSB  = 0;
  localparam logic [15:0] IFEC_CTRL_RST = 16'h0000;

  // Implemented flag bits per register
  localparam logic [15:0] IFEC_FLAG0_IMPL = 16'h3fef;
  localparam logic [15:0] IFEC_FLAG1_IMPL = 16'hfedf;
  localparam logic [15:0] IFEC_FLAG2_IMPL = 16'h3fe3;
  localparam logic [15:0] IFEC_PARPORT_MASK = 16'h2000;
  localparam logic [15:0] IFEC_FLAG_RST = 16'h0000;

  // Flag positions of the external inputs
  localparam int IFEC_EXT0_BIT = 0;
  localparam int IFEC_EXT1_BIT = 4;
  localparam int IFEC_EXT2_BIT = 13;

  // Event status and mask
  localparam logic [4:0] IFEC_EVT_RST = 5'h00;

  // AHB-Lite encodings
  localparam logic       IFEC_HRESP_OKAY = 1'b0;
  localparam logic [1:0] IFEC_HTRANS_IDLE = 2'h0;

  // Bus data phase
  typedef enum logic [1:0] {
    DP_IDLE,
    DP_WRITE,
    DP_RD_WAIT,
    DP_RD_DONE
  } ifec_dphase_t;

endpackage : ifec_pkg

// ---- core/ifec_top.sv ----
// Interrupt flag status, edge polarity and global control with an AHB-Lite slave
`timescale 1ns/100ps

//  Behaviour
// - The alternate vector table select bit is read/write, resets to 0 and drives the vector table choice.
// - The timed disable status bit follows the core's disable state, cannot be written and resets to 0.
// - Five read/write polarity bits, input 0 lowest and input 4 highest, reset to 0.
// - A polarity bit of 1 detects falling edges and 0 detects rising edges on its input.
// - Unused bits ignore writes and read 0, bits 13 to 5 in the control register.
// - Each implemented flag is set by its source, is software read/write and resets to 0.
// - A flag of 1 means its source has a pending request, 0 means none.
// - Flag register 0 bits 15-14 are unused and bits 13-8 are adc, uart1 tx, uart1 rx, spi1, spi1 fault, timer3.
// - Flag register 0 bits 7-5 are timer2, compare2, capture2, bit 4 unused, bits 3-0 timer1, compare1, capture1, ext0.
// - Flag register 1 bits 15-9 are uart2 tx, uart2 rx, ext2, timer5, timer4, compare4, compare3, bit 8 unused.
// - Flag register 1 bits 7-6 are capture8 and 7, bit 5 unused, bits 4-0 ext1, pin change, comparator, i2c1 m, i2c1 s.
// - Flag register 2 holds parallel port, compares 8-5, captures 6-3 and spi2 event and fault, others unused.
// - Without the parallel port the parallel port flag is absent and reads 0.
module ifec_top #(
  parameter bit HAS_PARALLEL_PORT = 1'b1
) (
  // Clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        resetn_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // Peripheral request pulses
  input  wire logic [15:0] flags0_req_i,
  input  wire logic [15:0] flags1_req_i,
  input  wire logic [15:0] flags2_req_i,
  // External interrupt pins
  input  wire logic [4:0]  ext_irq_i,
  // Core status and control
  input  wire logic        timed_irq_disable_active_i,
  output logic             alt_vector_table_select_o,
  output logic [15:0]      flags0_o,
  output logic [15:0]      flags1_o,
  output logic [15:0]      flags2_o,
  // Interrupt
  output logic             irq_o
);

  ifec_pkg::ifec_dphase_t dphase_reg;
  ifec_pkg::ifec_dphase_t dphase_next;
  logic [31:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_value;
  logic        ap_ok;
  logic        wr_ctrl;
  logic        wr_stat;
  logic        wr_mask;
  logic [2:0]  wr_flag;
  logic        alt_reg;
  logic        tdis_reg;
  logic [4:0]  pol_reg;
  logic [4:0]  sync1_reg;
  logic [4:0]  sync2_reg;
  logic [4:0]  prev_reg;
  logic [4:0]  rise;
  logic [4:0]  fall;
  logic [4:0]  ext_edge;
  logic [4:0]  evt_stat_reg;
  logic [4:0]  evt_mask_reg;
  logic [15:0] flag_reg [3];
  logic [15:0] set_all  [3];
  logic [15:0] impl_all [3];
  logic [15:0] req_all  [3];
  logic [31:0] flag_ofs [3];
  logic [15:0] ctrl_rd;

  // Bus address phase
  assign ap_ok = hsel_i && htrans_i[1] && hready_i;

  always_comb begin
    dphase_next = ifec_pkg::DP_IDLE;
    unique case (dphase_reg)
      ifec_pkg::DP_RD_WAIT: begin
        dphase_next = ifec_pkg::DP_RD_DONE;
      end
      ifec_pkg::DP_IDLE,
      ifec_pkg::DP_WRITE,
      ifec_pkg::DP_RD_DONE: begin
        if (ap_ok) begin
          dphase_next = hwrite_i ? ifec_pkg::DP_WRITE : ifec_pkg::DP_RD_WAIT;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      dphase_reg <= ifec_pkg::DP_IDLE;
    end else begin
      dphase_reg <= dphase_next;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      addr_reg <= 32'h0000_0000;
    end else if (ap_ok) begin
      addr_reg <= haddr_i;
    end
  end

  // One wait state on reads keeps hrdata on a flop after a preceding write
  assign hreadyout_o = (dphase_reg != ifec_pkg::DP_RD_WAIT);
  assign hresp_o     = ifec_pkg::IFEC_HRESP_OKAY;
  assign hrdata_o    = hrdata_reg;

  // Write strobes in the data phase
  assign flag_ofs[0] = ifec_pkg::IFEC_FLAG0_OFS;
  assign flag_ofs[1] = ifec_pkg::IFEC_FLAG1_OFS;
  assign flag_ofs[2] = ifec_pkg::IFEC_FLAG2_OFS;
  assign wr_ctrl = (dphase_reg == ifec_pkg::DP_WRITE) && (addr_reg == ifec_pkg::IFEC_CTRL_OFS);
  assign wr_stat = (dphase_reg == ifec_pkg::DP_WRITE) && (addr_reg == ifec_pkg::IFEC_EVT_STAT_OFS);
  assign wr_mask = (dphase_reg == ifec_pkg::DP_WRITE) && (addr_reg == ifec_pkg::IFEC_EVT_MASK_OFS);

  // Global control register
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      alt_reg <= ifec_pkg::IFEC_CTRL_RST[ifec_pkg::IFEC_ALT_BIT];
      pol_reg <= ifec_pkg::IFEC_CTRL_RST[4:0];
    end else if (wr_ctrl) begin
      alt_reg <= hwdata_i[ifec_pkg::IFEC_ALT_BIT];
      pol_reg <= hwdata_i[4:0];
    end
  end

  // Status only, bus writes never reach it
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      tdis_reg <= ifec_pkg::IFEC_CTRL_RST[ifec_pkg::IFEC_TDIS_BIT];
    end else begin
      tdis_reg <= timed_irq_disable_active_i;
    end
  end

  assign alt_vector_table_select_o = alt_reg;

  always_comb begin
    ctrl_rd = 16'h0000;
    ctrl_rd[ifec_pkg::IFEC_ALT_BIT]  = alt_reg;
    ctrl_rd[ifec_pkg::IFEC_TDIS_BIT] = tdis_reg;
    ctrl_rd[4:0] = pol_reg;
  end

  // Input synchroniser, first stage feeds only the second
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      sync1_reg <= 5'h00;
      sync2_reg <= 5'h00;
      prev_reg  <= 5'h00;
    end else begin
      sync1_reg <= ext_irq_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Changing a polarity bit can itself look like an edge on a steady pin: not so here,
  // edges come from pin history only
  assign rise = sync2_reg & ~prev_reg;
  assign fall = ~sync2_reg & prev_reg;
  assign ext_edge = (pol_reg & fall) | (~pol_reg & rise);

  // Flag sources
  assign req_all[0] = flags0_req_i;
  assign req_all[1] = flags1_req_i;
  assign req_all[2] = flags2_req_i;

  always_comb begin
    set_all[0] = req_all[0];
    set_all[1] = req_all[1];
    set_all[2] = req_all[2];
    set_all[0][ifec_pkg::IFEC_EXT0_BIT] = req_all[0][ifec_pkg::IFEC_EXT0_BIT] | ext_edge[0];
    set_all[1][ifec_pkg::IFEC_EXT1_BIT] = req_all[1][ifec_pkg::IFEC_EXT1_BIT] | ext_edge[1];
    set_all[1][ifec_pkg::IFEC_EXT2_BIT] = req_all[1][ifec_pkg::IFEC_EXT2_BIT] | ext_edge[2];
  end

  assign impl_all[0] = ifec_pkg::IFEC_FLAG0_IMPL;
  assign impl_all[1] = ifec_pkg::IFEC_FLAG1_IMPL;
  assign impl_all[2] = HAS_PARALLEL_PORT ? ifec_pkg::IFEC_FLAG2_IMPL
                     : (ifec_pkg::IFEC_FLAG2_IMPL & ~ifec_pkg::IFEC_PARPORT_MASK);

  // Flag registers
  for (genvar r = 0; r < ifec_pkg::IFEC_NUM_FLAG_REGS; r++) begin : g_flag
    assign wr_flag[r] = (dphase_reg == ifec_pkg::DP_WRITE) && (addr_reg == flag_ofs[r]);
    always_ff @(posedge clk_sys_i) begin
      if (!resetn_i) begin
        flag_reg[r] <= ifec_pkg::IFEC_FLAG_RST;
      end else if (wr_flag[r]) begin
        // Set ORed after the write so a request beats a clear
        flag_reg[r] <= (hwdata_i[15:0] | set_all[r]) & impl_all[r];
      end else begin
        flag_reg[r] <= (flag_reg[r] | set_all[r]) & impl_all[r];
      end
    end
  end

  assign flags0_o = flag_reg[0];
  assign flags1_o = flag_reg[1];
  assign flags2_o = flag_reg[2];

  // Edge event status, write one to clear, set wins
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      evt_stat_reg <= ifec_pkg::IFEC_EVT_RST;
    end else if (wr_stat) begin
      evt_stat_reg <= (evt_stat_reg & ~hwdata_i[4:0]) | ext_edge;
    end else begin
      evt_stat_reg <= evt_stat_reg | ext_edge;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      evt_mask_reg <= ifec_pkg::IFEC_EVT_RST;
    end else if (wr_mask) begin
      evt_mask_reg <= hwdata_i[4:0];
    end
  end

  assign irq_o = |(evt_stat_reg & evt_mask_reg);

  // Read mux, unmapped addresses read zero
  always_comb begin
    case (addr_reg)
      ifec_pkg::IFEC_CTRL_OFS:     rd_value = {16'h0000, ctrl_rd};
      ifec_pkg::IFEC_FLAG0_OFS:    rd_value = {16'h0000, flag_reg[0]};
      ifec_pkg::IFEC_FLAG1_OFS:    rd_value = {16'h0000, flag_reg[1]};
      ifec_pkg::IFEC_FLAG2_OFS:    rd_value = {16'h0000, flag_reg[2]};
      ifec_pkg::IFEC_EVT_STAT_OFS: rd_value = {27'h0000000, evt_stat_reg};
      ifec_pkg::IFEC_EVT_MASK_OFS: rd_value = {27'h0000000, evt_mask_reg};
      default:                     rd_value = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (dphase_reg == ifec_pkg::DP_RD_WAIT) begin
      hrdata_reg <= rd_value;
    end
  end

  // Checks
  AST_ALT_WRITE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_ctrl |=> alt_vector_table_select_o == $past(hwdata_i[15]))
    else $error("alt vector select not written");

  AST_TDIS_RO: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_ctrl && (hwdata_i[14] != timed_irq_disable_active_i) |=> tdis_reg == $past(timed_irq_disable_active_i))
    else $error("disable status bit took a bus write");

  AST_POL_WRITE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_ctrl |=> pol_reg == $past(hwdata_i[4:0]))
    else $error("polarity bits not written");

  AST_RISE_EDGE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !pol_reg[0] && $rose(ext_irq_i[0]) ##1 ext_irq_i[0] ##1 ext_irq_i[0] |=> flags0_o[0])
    else $error("rising edge on input 0 lost");

  AST_FALL_EDGE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    pol_reg[1] && $fell(ext_irq_i[1]) ##1 !ext_irq_i[1] ##1 !ext_irq_i[1] |=> flags1_o[4])
    else $error("falling edge on input 1 lost");

  AST_NO_WRONG_EDGE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ext_edge[2] |-> (pol_reg[2] ? fall[2] : rise[2]))
    else $error("edge of wrong polarity detected");

  AST_CTRL_UNUSED: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (dphase_reg == ifec_pkg::DP_RD_WAIT) && (addr_reg == ifec_pkg::IFEC_CTRL_OFS) |=> hrdata_o[13:5] == 9'h000)
    else $error("control unused bits not zero");

  AST_REQ_SETS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    flags1_req_i[15] |=> flags1_o[15])
    else $error("request did not set its flag");

  AST_FLAG_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    flags0_o[13] && !wr_flag[0] |=> flags0_o[13])
    else $error("flag cleared without software");

  AST_FLAG0_MAP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (flags0_o & ~ifec_pkg::IFEC_FLAG0_IMPL) == 16'h0000)
    else $error("unused bit set in flag register 0");

  AST_FLAG0_EXT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !flags0_o[0] && !wr_flag[0] && !flags0_req_i[0] && !ext_edge[0] |=> !flags0_o[0])
    else $error("ext 0 flag set with no cause");

  AST_FLAG1_MAP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (flags1_o & ~ifec_pkg::IFEC_FLAG1_IMPL) == 16'h0000)
    else $error("unused bit set in flag register 1");

  AST_FLAG1_EXT2: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ext_edge[2] |=> flags1_o[13] ##1 (flags1_o[13] || $past(wr_flag[1])))
    else $error("ext 2 flag not set by its edge");

  AST_FLAG2_MAP: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (flags2_o & ~ifec_pkg::IFEC_FLAG2_IMPL) == 16'h0000)
    else $error("unused bit set in flag register 2");

  AST_NO_PARPORT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !HAS_PARALLEL_PORT |-> !flags2_o[13])
    else $error("parallel port flag present");

  AST_SET_WINS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_flag[2] && !hwdata_i[1] && flags2_req_i[1] |=> flags2_o[1])
    else $error("request lost to a clearing write");

  AST_SYNC_DELAY: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ext_edge[3] |-> $past(ext_irq_i[3], 2) != $past(ext_irq_i[3], 3))
    else $error("edge not three cycles after the pin");

  AST_SINGLE_EDGE: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ext_edge[4] |=> !ext_edge[4])
    else $error("one pin edge gave two events");

  AST_IRQ_EVT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ext_edge[0] && evt_mask_reg[0] && !wr_mask |=> irq_o)
    else $error("masked-in event did not raise irq");

  AST_READ_WAIT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ap_ok && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
    else $error("read not answered after one wait");

  AST_ALT_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !wr_ctrl |=> $stable(alt_vector_table_select_o))
    else $error("alt vector select changed without a write");

  AST_TDIS_TRACK: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    resetn_i |=> tdis_reg == $past(timed_irq_disable_active_i))
    else $error("disable status bit lost the core state");

  AST_POL_HOLD: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    !wr_ctrl |=> $stable(pol_reg))
    else $error("polarity bits changed without a write");

  AST_EDGE_TO_EVT: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ext_edge[4] |=> evt_stat_reg[4])
    else $error("input 4 edge not recorded");

  AST_CTRL_UPPER: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    (dphase_reg == ifec_pkg::DP_RD_WAIT) && (addr_reg == ifec_pkg::IFEC_CTRL_OFS) |=> hrdata_o[31:16] == 16'h0000)
    else $error("control upper half not zero");

  AST_SW_SETS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_flag[0] && hwdata_i[13] |=> flags0_o[13])
    else $error("software write of one did not set the flag");

  AST_SW_CLEARS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    wr_flag[1] && !hwdata_i[15] && !flags1_req_i[15] |=> !flags1_o[15])
    else $error("software write of zero did not clear the flag");

  AST_PARPORT_SETS: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    HAS_PARALLEL_PORT && flags2_req_i[13] |=> flags2_o[13])
    else $error("parallel port request lost");

  AST_EXT1_FLAG: assert property (@(posedge clk_sys_i) disable iff (!resetn_i)
    ext_edge[1] |=> flags1_o[4])
    else $error("input 1 edge did not set its flag");

endmodule : ifec_top

// ---- verif/ifec_src_model.sv ----
// Peripheral request sources and external interrupt pins facing the block
`timescale 1ns/100ps
module ifec_src_model (
  // Clock
  input  wire logic        clk_sys_i,
  // Request pulses and pins
  output logic [15:0]      flags0_req_o,
  output logic [15:0]      flags1_req_o,
  output logic [15:0]      flags2_req_o,
  output logic [4:0]       ext_irq_o
);
  initial begin
    flags0_req_o = 16'h0000;
    flags1_req_o = 16'h0000;
    flags2_req_o = 16'h0000;
    ext_irq_o    = 5'h00;
  end

  // One-cycle request, called right after a rising edge
  task automatic pulse(input int k, input logic [15:0] v);
    case (k)
      0: flags0_req_o <= v;
      1: flags1_req_o <= v;
      default: flags2_req_o <= v;
    endcase
    @(posedge clk_sys_i);
    flags0_req_o <= 16'h0000;
    flags1_req_o <= 16'h0000;
    flags2_req_o <= 16'h0000;
  endtask : pulse

  // Pins are always driven, so no floating level
  task automatic set_pins(input logic [4:0] v);
    ext_irq_o <= v;
  endtask : set_pins
endmodule : ifec_src_model

// ---- verif/ifec_top_tb_top.sv ----
// Self-checking bench for the interrupt flag and edge control block
`timescale 1ns/100ps
module ifec_top_tb_top;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        hsel;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic        tdis;
  logic [15:0] fl2_np;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic [15:0] req0, req1, req2, fl0, fl1, fl2;
  logic [4:0]  pins, pol, pa, pb, ev, msk;
  logic        alt;
  logic        irq;
  logic [31:0] exp_q[$];
  logic [31:0] seed;
  logic [31:0] r;
  logic        rd_ph;
  int          n_fail, n_checks, cyc;

  ifec_top u_ifec_top (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(hreadyout),
    .hresp_o(hresp), .hrdata_o(hrdata), .flags0_req_i(req0), .flags1_req_i(req1), .flags2_req_i(req2),
    .ext_irq_i(pins), .timed_irq_disable_active_i(tdis), .alt_vector_table_select_o(alt),
    .flags0_o(fl0), .flags1_o(fl1), .flags2_o(fl2), .irq_o(irq));

  // Build without the parallel port, sharing bus and request pins
  ifec_top #(
    .HAS_PARALLEL_PORT(1'b0)
  ) u_ifec_top_np (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hreadyout), .hreadyout_o(),
    .hresp_o(), .hrdata_o(), .flags0_req_i(req0), .flags1_req_i(req1), .flags2_req_i(req2),
    .ext_irq_i(pins), .timed_irq_disable_active_i(tdis), .alt_vector_table_select_o(),
    .flags0_o(), .flags1_o(), .flags2_o(fl2_np), .irq_o());

  ifec_src_model u_ifec_src_model (
    .clk_sys_i(clk_sys_i), .flags0_req_o(req0), .flags1_req_o(req1), .flags2_req_o(req2), .ext_irq_o(pins));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  function automatic logic [31:0] impl_of(input int k);
    return (k == 0) ? {16'h0, ifec_pkg::IFEC_FLAG0_IMPL} :
           (k == 1) ? {16'h0, ifec_pkg::IFEC_FLAG1_IMPL} : {16'h0, ifec_pkg::IFEC_FLAG2_IMPL};
  endfunction : impl_of

  task automatic chk_rd(input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR read data expected %h seen %h", e, s);
    end
  endtask : chk_rd

  task automatic chk_pin(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_pin

  task automatic wrap_up();
    $display("Comparisons %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up

  // Master holds each phase until hready is seen high at a rising edge
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge clk_sys_i iff hreadyout === 1'b1);
    hsel <= 1'b0;
    htrans <= ifec_pkg::IFEC_HTRANS_IDLE;
    hwdata <= d;
    @(posedge clk_sys_i iff hreadyout === 1'b1);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask : rd

  // Read monitor: takes the oldest note when a read data phase completes
  always @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      rd_ph <= 1'b0;
    end else if (hreadyout === 1'b1) begin
      if (rd_ph === 1'b1) begin
        chk_rd(exp_q.pop_front(), hrdata);
        chk_pin("hresp", {15'h0, ifec_pkg::IFEC_HRESP_OKAY}, {15'h0, hresp});
      end
      rd_ph <= hsel & htrans[1] & ~hwrite;
    end
  end

  // Whole run needs a few hundred cycles
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      wrap_up();
    end
  end

  initial begin
    resetn_i = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    tdis = 1'b0;
    seed = 32'h0001_2ed8; // 77528
    repeat (12) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    // Reset values, unmapped word at 0x18 included
    for (int a = 0; a <= 32'h18; a += 4) rd(a, 32'h0000_0000);
    chk_pin("alt", 16'h0, {15'h0, alt});
    wr(32'h0000_0018, 32'hffff_ffff);
    rd(32'h0000_0018, 32'h0000_0000);
    // Control register access kinds
    wr(ifec_pkg::IFEC_CTRL_OFS, 32'hffff_ffff);
    rd(ifec_pkg::IFEC_CTRL_OFS, 32'h0000_801f);
    chk_pin("alt", 16'h1, {15'h0, alt});
    tdis <= 1'b1;
    rd(ifec_pkg::IFEC_CTRL_OFS, 32'h0000_c01f);
    wr(ifec_pkg::IFEC_CTRL_OFS, 32'h0000_0000);
    rd(ifec_pkg::IFEC_CTRL_OFS, 32'h0000_4000);
    tdis <= 1'b0;
    chk_pin("alt", 16'h0, {15'h0, alt});
    // Flag layouts, hardware set and software clear
    for (int k = 0; k < 3; k++) begin
      wr(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, 32'hffff_ffff);
      rd(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, impl_of(k));
      if (k == 2) chk_pin("flags2_np", 16'h1fe3, fl2_np);
      wr(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, 32'h0000_0000);
      seed = lfsr(seed);
      r = seed;
      u_ifec_src_model.pulse(k, r[15:0]);
      rd(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, {16'h0, r[15:0]} & impl_of(k));
      wr(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, 32'h0000_0000);
      rd(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, 32'h0000_0000);
    end
    chk_pin("flags2", 16'h0, fl2);
    // Request lands on the same edge as a clearing write, in flag registers 0 and 2
    for (int k = 0; k < 3; k += 2) begin
      fork
        wr(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, 32'h0000_0000);
        begin
          @(posedge clk_sys_i);
          u_ifec_src_model.pulse(k, (k == 0) ? 16'h2000 : 16'h0002);
        end
      join
      rd(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, (k == 0) ? 32'h0000_2000 : 32'h0000_0002);
      chk_pin("flags", (k == 0) ? 16'h2000 : 16'h0002, (k == 0) ? fl0 : fl2);
      wr(ifec_pkg::IFEC_FLAG0_OFS + 4 * k, 32'h0000_0000);
    end
    // Random polarity and pin moves; only selected edges count
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      pol = seed[4:0];
      pa = seed[9:5];
      pb = seed[14:10];
      msk = seed[19:15];
      wr(ifec_pkg::IFEC_CTRL_OFS, {27'h0, pol});
      u_ifec_src_model.set_pins(pa);
      repeat (5) @(posedge clk_sys_i);
      wr(ifec_pkg::IFEC_EVT_STAT_OFS, 32'h0000_001f);
      wr(ifec_pkg::IFEC_FLAG0_OFS, 32'h0000_0000);
      wr(ifec_pkg::IFEC_FLAG1_OFS, 32'h0000_0000);
      wr(ifec_pkg::IFEC_EVT_MASK_OFS, {27'h0, msk});
      ev = (pol & pa & ~pb) | (~pol & ~pa & pb);
      u_ifec_src_model.set_pins(pb);
      repeat (5) @(posedge clk_sys_i);
      rd(ifec_pkg::IFEC_EVT_STAT_OFS, {27'h0, ev});
      rd(ifec_pkg::IFEC_FLAG0_OFS, {31'h0, ev[0]});
      rd(ifec_pkg::IFEC_FLAG1_OFS, {18'h0, ev[2], 8'h0, ev[1], 4'h0});
      chk_pin("flags1", {2'h0, ev[2], 8'h00, ev[1], 4'h0}, fl1);
      chk_pin("irq", {15'h0, |(ev & msk)}, {15'h0, irq});
    end
    wr(ifec_pkg::IFEC_EVT_STAT_OFS, 32'h0000_001f);
    // The clearing write lands on the edge the task returns at
    @(posedge clk_sys_i);
    chk_pin("irq", 16'h0, {15'h0, irq});
    repeat (2) @(posedge clk_sys_i);
    wrap_up();
  end
endmodule : ifec_top_tb_top
